// ==== verilog/boot_seq_defs.vh ====
// Constants for the boot strap and power sequencer
`ifndef BOOT_SEQ_DEFS_VH
`define BOOT_SEQ_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_STATUS     8'h00
`define OFF_CONTROL    8'h04
`define OFF_DEFCFG     8'h08

// ----------------------------------------------------------------
// Control field positions and reset value
// ----------------------------------------------------------------
`define CTL_LOAD_OK    0
`define CTL_LOAD_FAIL  1
`define CTL_IDLE_REQ   2
`define CTL_SLEEP_REQ  3
`define CTL_CFG_INT    4
`define CTL_CFG_EXT    5
`define CTL_RESET_VAL  32'h00000000

// ----------------------------------------------------------------
// Dead-battery modes
// ----------------------------------------------------------------
`define DB_NO_RESPONSE 3'h0
`define DB_WAIT_AUX_INT 3'h1
`define DB_RETRY_INT   3'h2
`define DB_WAIT_AUX_EXT 3'h3
`define DB_RETRY_EXT   3'h4
`define DB_NO_WAIT     3'h5

// ----------------------------------------------------------------
// Default configurations
// ----------------------------------------------------------------
`define DEF_SAFE       3'h0
`define DEF_INFINITE   3'h1
`define DEF_CFG1       3'h2
`define DEF_CFG2       3'h3
`define DEF_CFG3       3'h4
`define DEF_CFG4       3'h5
`define DEF_CFG5       3'h6
`define DEF_RESERVED   3'h7

// ----------------------------------------------------------------
// Power states
// ----------------------------------------------------------------
`define PWR_ACTIVE     2'h0
`define PWR_IDLE       2'h1
`define PWR_SLEEP      2'h2

// Divider band code is ratio in hundredths, 0..100
`define BAND_W         7

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
// Init cycles so strap capture sees filtered pin levels, not reset zeros
`define SYNC_SETTLE    3'h4

`endif

// ==== verilog/boot_strap_power_sequencer.v ====
// Boot strap decode, dead-battery power switch and power state sequencer
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`include "boot_seq_defs.vh"

module boot_strap_power_sequencer (
   input  wire        clk,              // 24 MHz core clock
   input  wire        nrst,             // Async reset, active low
   input  wire        lpTick,           // 100 kHz tick from timer oscillator
   input  wire        flashDataInStrap, // Strap level on flash data-in pin
   input  wire [6:0]  bootDividerBand,  // Decoded divider ratio, hundredths
   input  wire        bandValid,        // Divider conversion ready
   input  wire        auxSupply3v3,     // Auxiliary 3.3 V present
   input  wire        vbusPowered,      // Device running from VBUS
   input  wire        portConnected,    // Any port connected
   output reg         loadReq,          // Configuration fetch request
   output reg         hvPathOneEn,      // Internal sink switch enable
   output reg         extSinkCtrlPin,   // External sink switch control
   output reg         portsEnabled,     // Ports enabled
   output reg         legacySink,       // Legacy sink behaviour
   output reg         coreLowClk,       // Core runs from 100 kHz
   output reg  [1:0]  powerState,       // Active, idle or sleep
   output reg         bootDone,         // Normal operation started
   input  wire [31:0] s_axi_awaddr,     // Write address
   input  wire        s_axi_awvalid,    // Write address valid
   output wire        s_axi_awready,    // Write address ready
   input  wire [31:0] s_axi_wdata,      // Write data
   input  wire [3:0]  s_axi_wstrb,      // Write strobes
   input  wire        s_axi_wvalid,     // Write data valid
   output wire        s_axi_wready,     // Write data ready
   output reg  [1:0]  s_axi_bresp,      // Write response
   output reg         s_axi_bvalid,     // Write response valid
   input  wire        s_axi_bready,     // Write response ready
   input  wire [31:0] s_axi_araddr,     // Read address
   input  wire        s_axi_arvalid,    // Read address valid
   output wire        s_axi_arready,    // Read address ready
   output reg  [31:0] s_axi_rdata,      // Read data
   output reg  [1:0]  s_axi_rresp,      // Read response
   output reg         s_axi_rvalid,     // Read data valid
   input  wire        s_axi_rready      // Read response ready
);

   // ----------------------------------------------------------------
   // Boot state machine codes
   // ----------------------------------------------------------------
   localparam S_INIT    = 3'h0;       // Register init
   localparam S_STRAP   = 3'h1;       // Capture straps
   localparam S_POWER   = 3'h2;       // Dead-battery switch handling
   localparam S_LOAD    = 3'h3;       // Configuration fetch
   localparam S_DEFAULT = 3'h4;       // Apply strap default
   localparam S_RUN     = 3'h5;       // Normal operation
   localparam S_WAITCFG = 3'h6;       // Infinite wait in boot

   // ----------------------------------------------------------------
   // Strap decode functions
   // ----------------------------------------------------------------
   // Dead-battery mode from strap and band; gaps fall to no-response
   function [2:0] dbMode;
      input       strap;
      input [6:0] b;
      begin
         dbMode = `DB_NO_RESPONSE;
         if (strap) begin
            if (b <= 7'd18)                      dbMode = `DB_NO_RESPONSE;
            else if (b >= 7'd20 && b <= 7'd28)   dbMode = `DB_WAIT_AUX_INT;
            else if (b >= 7'd30 && b <= 7'd38)   dbMode = `DB_RETRY_INT;
            else if (b >= 7'd40 && b <= 7'd48)   dbMode = `DB_WAIT_AUX_EXT;
            else if (b >= 7'd50 && b <= 7'd58)   dbMode = `DB_RETRY_EXT;
            else if (b >= 7'd60)                 dbMode = `DB_NO_WAIT;
         end else begin
            if (b >= 7'd20 && b <= 7'd28)        dbMode = `DB_NO_WAIT;
            else if (b >= 7'd30 && b <= 7'd38)   dbMode = `DB_RETRY_INT;
            else if (b >= 7'd40 && b <= 7'd48)   dbMode = `DB_NO_WAIT;
            else if (b >= 7'd50 && b <= 7'd58)   dbMode = `DB_RETRY_EXT;
            else if (b >= 7'd60 && b <= 7'd68)   dbMode = `DB_NO_WAIT;
            else if (b >= 7'd70 && b <= 7'd78)   dbMode = `DB_NO_WAIT;
            else if (b >= 7'd90)                 dbMode = `DB_NO_WAIT;
         end
      end
   endfunction

   // Default configuration from strap and band; gaps fall to safe
   function [2:0] defCfg;
      input       strap;
      input [6:0] b;
      begin
         defCfg = `DEF_SAFE;
         if (strap) begin
            if ((b >= 7'd30 && b <= 7'd38) || (b >= 7'd50 && b <= 7'd58))
               defCfg = `DEF_INFINITE;
         end else begin
            if (b >= 7'd10 && b <= 7'd18)        defCfg = `DEF_CFG1;
            else if (b >= 7'd20 && b <= 7'd28)   defCfg = `DEF_CFG2;
            else if (b >= 7'd30 && b <= 7'd38)   defCfg = `DEF_INFINITE;
            else if (b >= 7'd40 && b <= 7'd48)   defCfg = `DEF_CFG3;
            else if (b >= 7'd50 && b <= 7'd58)   defCfg = `DEF_INFINITE;
            else if (b >= 7'd60 && b <= 7'd68)   defCfg = `DEF_CFG4;
            else if (b >= 7'd70 && b <= 7'd88)   defCfg = `DEF_RESERVED;
            else if (b >= 7'd90)                 defCfg = `DEF_CFG5;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers, three stages, change once stages 1 and 2 agree
   // ----------------------------------------------------------------
   reg  [2:0] auxSync_reg;            // Aux supply sync chain
   reg  [2:0] vbusSync_reg;           // VBUS source sync chain
   reg  [2:0] strapSync_reg;          // Strap sync chain
   reg  [2:0] connSync_reg;           // Connect sync chain
   reg        auxLvl_reg;             // Filtered aux level
   reg        vbusLvl_reg;            // Filtered VBUS level
   reg        strapLvl_reg;           // Filtered strap level
   reg        connLvl_reg;            // Filtered connect level

   // Sync chains; stage 0 feeds only stage 1
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         auxSync_reg   <= 3'h0;
         vbusSync_reg  <= 3'h0;
         strapSync_reg <= 3'h0;
         connSync_reg  <= 3'h0;
         auxLvl_reg    <= 1'b0;
         vbusLvl_reg   <= 1'b0;
         strapLvl_reg  <= 1'b0;
         connLvl_reg   <= 1'b0;
      end else begin
         auxSync_reg   <= {auxSync_reg[1:0], auxSupply3v3};
         vbusSync_reg  <= {vbusSync_reg[1:0], vbusPowered};
         strapSync_reg <= {strapSync_reg[1:0], flashDataInStrap};
         connSync_reg  <= {connSync_reg[1:0], portConnected};
         if (auxSync_reg[2] == auxSync_reg[1])     auxLvl_reg   <= auxSync_reg[2];
         if (vbusSync_reg[2] == vbusSync_reg[1])   vbusLvl_reg  <= vbusSync_reg[2];
         if (strapSync_reg[2] == strapSync_reg[1]) strapLvl_reg <= strapSync_reg[2];
         if (connSync_reg[2] == connSync_reg[1])   connLvl_reg  <= connSync_reg[2];
      end
   end

   // ----------------------------------------------------------------
   // Control and captured strap state
   // ----------------------------------------------------------------
   reg  [2:0]  state_reg;             // Boot state
   reg  [2:0]  state_next;            // Next boot state
   reg  [2:0]  dbMode_reg;            // Captured dead-battery mode
   reg  [2:0]  defCfg_reg;            // Captured default config
   reg  [6:0]  band_reg;              // Captured divider band
   reg         strapCap_reg;          // Captured strap level
   reg  [31:0] control_reg;           // Software control word
   reg  [31:0] retries_reg;           // Cycles with load failure set in load or wait
   reg         usedDefault_reg;       // Default applied flag
   reg  [2:0]  lpSync_reg;            // Low-power tick sync
   reg         lpSeen_reg;            // Filtered low-power tick level
   reg  [2:0]  initCnt_reg;           // Init cycles while pin filters fill
   wire        loadOk   = control_reg[`CTL_LOAD_OK];
   wire        loadFail = control_reg[`CTL_LOAD_FAIL];
   wire        isInt    = (dbMode_reg == `DB_WAIT_AUX_INT) || (dbMode_reg == `DB_RETRY_INT);
   wire        isExt    = (dbMode_reg == `DB_WAIT_AUX_EXT) || (dbMode_reg == `DB_RETRY_EXT);
   wire        isRetry  = (dbMode_reg == `DB_RETRY_INT) || (dbMode_reg == `DB_RETRY_EXT);

   // Boot sequence next state
   always @* begin
      state_next = state_reg;
      case (state_reg)
         S_INIT:    if (initCnt_reg == `SYNC_SETTLE) state_next = S_STRAP;
         S_STRAP:   if (bandValid) state_next = S_POWER;
         S_POWER: begin
            // Dead-battery gating only applies on VBUS power
            if (!vbusLvl_reg || auxLvl_reg)
               state_next = S_LOAD;
            else if (dbMode_reg == `DB_NO_WAIT || isRetry)
               state_next = S_LOAD;
         end
         S_LOAD: begin
            if (loadOk)
               state_next = S_RUN;
            else if (loadFail && !(isRetry && vbusLvl_reg && !auxLvl_reg))
               state_next = S_DEFAULT;
         end
         S_DEFAULT:
            if (defCfg_reg == `DEF_INFINITE) state_next = S_WAITCFG;
            else state_next = S_RUN;
         S_WAITCFG: if (loadOk) state_next = S_RUN;
         S_RUN:     state_next = S_RUN;
         default:   state_next = S_INIT;
      endcase
   end

   // Boot state, strap capture and retry count
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg       <= S_INIT;
         dbMode_reg      <= `DB_NO_RESPONSE;
         defCfg_reg      <= `DEF_SAFE;
         band_reg        <= 7'h00;
         strapCap_reg    <= 1'b0;
         retries_reg     <= 32'h00000000;
         usedDefault_reg <= 1'b0;
         initCnt_reg     <= 3'h0;
      end else begin
         state_reg <= state_next;
         // Capturing earlier would latch the filters' reset level
         if (state_reg == S_INIT && initCnt_reg != `SYNC_SETTLE)
            initCnt_reg <= initCnt_reg + 3'h1;
         if (state_reg == S_STRAP && bandValid) begin
            dbMode_reg   <= dbMode(strapLvl_reg, bootDividerBand);
            defCfg_reg   <= defCfg(strapLvl_reg, bootDividerBand);
            band_reg     <= bootDividerBand;
            strapCap_reg <= strapLvl_reg;
         end
         if ((state_reg == S_LOAD || state_reg == S_WAITCFG) && loadFail)
            retries_reg <= retries_reg + 32'h00000001;
         if (state_reg == S_DEFAULT)
            usedDefault_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Power switches and port configuration outputs
   // ----------------------------------------------------------------
   // Switches: dead-battery path through load and wait, loaded/default after
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         loadReq        <= 1'b0;
         hvPathOneEn    <= 1'b0;
         extSinkCtrlPin <= 1'b0;
         portsEnabled   <= 1'b0;
         legacySink     <= 1'b0;
         bootDone       <= 1'b0;
      end else begin
         loadReq  <= (state_next == S_LOAD) || (state_next == S_WAITCFG);
         bootDone <= (state_reg == S_RUN);
         if (state_reg != S_RUN && state_reg != S_DEFAULT) begin
            // Dead-battery sink path while still booting on VBUS
            hvPathOneEn    <= vbusLvl_reg && isInt && state_reg != S_INIT
                              && state_reg != S_STRAP;
            extSinkCtrlPin <= vbusLvl_reg && isExt && state_reg != S_INIT
                              && state_reg != S_STRAP;
         end else if (state_reg == S_DEFAULT) begin
            case (defCfg_reg)
               `DEF_CFG1, `DEF_CFG2, `DEF_CFG3: begin
                  hvPathOneEn    <= 1'b1;
                  extSinkCtrlPin <= 1'b0;
                  portsEnabled   <= 1'b1;
               end
               `DEF_CFG4, `DEF_CFG5: begin
                  hvPathOneEn    <= 1'b0;
                  extSinkCtrlPin <= 1'b1;
                  portsEnabled   <= 1'b1;
               end
               `DEF_INFINITE: begin
                  portsEnabled   <= 1'b0;
               end
               default: begin
                  portsEnabled   <= 1'b0;
                  legacySink     <= vbusLvl_reg;
                  hvPathOneEn    <= 1'b0;
                  extSinkCtrlPin <= 1'b0;
               end
            endcase
         end else if (!usedDefault_reg) begin
            // Loaded configuration designates the switch after load
            hvPathOneEn    <= control_reg[`CTL_CFG_INT];
            extSinkCtrlPin <= control_reg[`CTL_CFG_EXT];
            portsEnabled   <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Power states
   // ----------------------------------------------------------------
   // Sleep is refused while connected; connect allows only active or idle
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         powerState <= `PWR_ACTIVE;
         coreLowClk <= 1'b0;
         lpSync_reg <= 3'h0;
         lpSeen_reg <= 1'b0;
      end else begin
         lpSync_reg <= {lpSync_reg[1:0], lpTick};
         lpSeen_reg <= (lpSync_reg[2] == lpSync_reg[1]) ? lpSync_reg[2] : lpSeen_reg;
         if (state_reg != S_RUN || connLvl_reg)
            powerState <= (state_reg == S_RUN && control_reg[`CTL_IDLE_REQ])
                          ? `PWR_IDLE : `PWR_ACTIVE;
         else if (control_reg[`CTL_SLEEP_REQ])
            powerState <= `PWR_SLEEP;
         else if (control_reg[`CTL_IDLE_REQ])
            powerState <= `PWR_IDLE;
         else
            powerState <= `PWR_ACTIVE;
         coreLowClk <= (powerState == `PWR_SLEEP);
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   reg        awHeld_reg;             // Write address captured
   reg        wHeld_reg;              // Write data captured
   reg [7:0]  awAddr_reg;             // Captured write address
   reg [31:0] wData_reg;              // Captured write data
   reg [3:0]  wStrb_reg;              // Captured strobes
   integer    i;                      // Byte lane index

   assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // Write path; address and data in either order
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         awHeld_reg   <= 1'b0;
         wHeld_reg    <= 1'b0;
         awAddr_reg   <= 8'h00;
         wData_reg    <= 32'h00000000;
         wStrb_reg    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
         control_reg  <= `CTL_RESET_VAL;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr[7:0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (awHeld_reg && wHeld_reg) begin
            awHeld_reg   <= 1'b0;
            wHeld_reg    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awAddr_reg == `OFF_CONTROL) begin
               s_axi_bresp <= 2'h0;
               for (i = 0; i < 4; i = i + 1)
                  if (wStrb_reg[i])
                     control_reg[i*8 +: 8] <= wData_reg[i*8 +: 8];
            end else begin
               s_axi_bresp <= 2'h2;                                  // Any offset but CONTROL: SLVERR
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read path; status shows boot state, captured straps, power state
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'h0;
         case (s_axi_araddr[7:0])
            `OFF_STATUS:  s_axi_rdata <= {9'h000, lpSeen_reg, coreLowClk, powerState,
                                          band_reg, strapCap_reg, usedDefault_reg,
                                          bootDone, defCfg_reg, dbMode_reg, state_reg};
            `OFF_CONTROL: s_axi_rdata <= control_reg;
            `OFF_DEFCFG:  s_axi_rdata <= retries_reg;
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // boot_strap_power_sequencer

// ==== testbench/boot_seq_checker.sv ====
// Checker for the sequencer outputs and its read channel
`include "boot_seq_defs.vh"
module boot_seq_checker (
   input wire logic       clk,           // Core clock
   input wire logic       nrst,          // Reset, active low
   input wire logic       portConnected, // Port attached
   input wire logic       loadReq,       // Fetch request
   input wire logic       bootDone,      // Boot finished
   input wire logic       coreLowClk,    // Slow core clock
   input wire logic [1:0] powerState,    // Power state
   input wire logic       s_axi_arvalid, // Read address valid
   input wire logic       s_axi_arready, // Read address ready
   input wire logic       s_axi_rvalid,  // Read data valid
   input wire logic       s_axi_rready   // Read data ready
);
   // ----------------------------------------
   // Properties, all in the core clock domain
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Connected for six cycles covers the input synchroniser lag
   sleep_unconn_a: assert property (portConnected [*6] |-> powerState != `PWR_SLEEP)
      else $error("sleep while connected");
   one_state_a: assert property (powerState != 2'h3)
      else $error("illegal power state");
   done_idle_a: assert property (bootDone |-> !loadReq)
      else $error("fetching after boot");
   done_stays_a: assert property (bootDone |=> bootDone)
      else $error("boot done dropped");
   quiet_start_a: assert property ($rose(nrst) |-> !bootDone && !loadReq)
      else $error("active right after reset");
   low_clk_a: assert property (powerState == `PWR_SLEEP [*2] |-> coreLowClk)
      else $error("sleep without slow clock");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read answer withdrawn");
   read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address taken while busy");
   cover property (powerState == `PWR_SLEEP);
   cover property ($rose(bootDone));
   cover property (s_axi_arvalid && s_axi_arready);
endmodule // boot_seq_checker
bind boot_strap_power_sequencer boot_seq_checker checkerInst (.clk, .nrst, .portConnected,
   .loadReq, .bootDone, .coreLowClk, .powerState, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready);

// ==== testbench/board_model.sv ====
// Board model: divider converter and free-running slow oscillator
module board_model (
   input  wire logic       clk,      // Core clock
   input  wire logic [6:0] bandSel,  // Divider ratio on board
   output logic            lpTick,   // Slow oscillator
   output logic [6:0]      band,     // Converted ratio
   output logic            bandValid // Conversion ready
);
   logic [3:0] lpDivReg  = 4'h0; // Slow clock divider
   logic [2:0] settleReg = 3'h0; // Conversion delay
   // Any ratio change restarts the conversion, so ready comes late
   always @(posedge clk) begin
      band      <= bandSel;
      settleReg <= (band !== bandSel) ? 3'h0 : settleReg + {2'h0, settleReg != 3'h7};
      lpDivReg  <= lpDivReg + 4'h1;
   end
   assign bandValid = (settleReg == 3'h7);
   assign lpTick    = lpDivReg[3];
endmodule // board_model

// ==== testbench/test_boot_strap_power_sequencer.sv ====
// Self-checking bench for the boot strap and power sequencer
`include "boot_seq_defs.vh"
module test_boot_strap_power_sequencer;
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------
   // Signals, tables
   // ---------------
   logic        clk = 1'b0, nrst = 1'b0, strap = 1'b0, aux = 1'b0, vbus = 1'b0, conn = 1'b0;
   logic        lpTick, bandValid, loadReq, hvOn, extOn, portsOn, legacy, lowClk, done;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [6:0]  bandSel = 7'h0, band;
   logic [1:0]  pState, bresp, rresp, r;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, st;
   int          badCount = 0, numChecks = 0, cyc = 0;
   // Strap in bit 7, ratio below; expected {defCfg, dbMode}
   logic [7:0]  bandTab [15] = '{8'h8a, 8'h99, 8'ha3, 8'had, 8'hb7, 8'hd0, 8'h0f, 8'h19,
                                 8'h23, 8'h2d, 8'h37, 8'h41, 8'h4b, 8'h55, 8'h5f};
   logic [5:0]  expTab [15] = '{6'h00, 6'h01, 6'h0a, 6'h03, 6'h0c, 6'h05, 6'h10, 6'h1d,
                                6'h0a, 6'h25, 6'h0c, 6'h2d, 6'h3d, 6'h38, 6'h35};
   always #2.5 clk = ~clk;
   board_model board (.clk, .bandSel, .lpTick, .band, .bandValid);
   boot_strap_power_sequencer DUT (.clk, .nrst, .lpTick, .flashDataInStrap(strap),
      .bootDividerBand(band), .bandValid, .auxSupply3v3(aux), .vbusPowered(vbus),
      .portConnected(conn), .loadReq, .hvPathOneEn(hvOn), .extSinkCtrlPin(extOn),
      .portsEnabled(portsOn), .legacySink(legacy), .coreLowClk(lowClk), .powerState(pState),
      .bootDone(done), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   // ------------------
   // Tasks
   // ------------------
   task automatic completeRun;
      $display("checks %0d mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      numChecks++;
      if (g !== e) begin
         badCount++;
         $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic pause;
      repeat (20) @(posedge clk);
   endtask
   // Straps are set while reset is held, as on a board at power-on
   task automatic boot(input logic s, input logic [6:0] b, input logic v, input logic x);
      nrst    <= 1'b0;
      strap   <= s;
      bandSel <= b;
      vbus    <= v;
      aux     <= x;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      pause;
   endtask
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      st = rdata;
      r  = rresp;
      rready <= 1'b0;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         badCount++;
         completeRun;
      end
   end
   // ------------------
   // Main sequence
   // ------------------
   initial begin
      boot(1'b0, 7'h0f, 1'b0, 1'b1);
      rd(`OFF_CONTROL);
      chk({r, st}, {2'h0, `CTL_RESET_VAL});
      rd(32'h0c);
      chk({r, st}, {2'h2, 32'h0});
      wr(`OFF_STATUS, 32'h1);
      chk(r, 2'h2);
      wr(32'h10, 32'h1);
      chk(r, 2'h2);
      for (int i = 0; i < 15; i++) begin
         boot(bandTab[i][7], bandTab[i][6:0], 1'b0, 1'b1);
         rd(`OFF_STATUS);
         chk(st[8:3], expTab[i]);
      end
      strap   <= 1'b1;
      bandSel <= 7'h0a;
      pause;
      rd(`OFF_STATUS);
      chk({st[11], st[18:12]}, 8'h5f);
      boot(1'b1, 7'h0a, 1'b1, 1'b0);
      chk({hvOn, extOn, loadReq}, 3'b000);
      aux <= 1'b1;
      pause;
      chk(loadReq, 1'b1);
      boot(1'b1, 7'h23, 1'b1, 1'b0);
      chk({hvOn, extOn, loadReq}, 3'b101);
      wr(`OFF_CONTROL, 32'h2);
      pause;
      chk({hvOn, extOn, loadReq, done}, 4'b1010);
      wr(`OFF_CONTROL, 32'h1);
      pause;
      chk({loadReq, done}, 2'b01);
      wr(`OFF_CONTROL, 32'h8);
      pause;
      chk({pState, lowClk}, 3'b101);
      rd(`OFF_CONTROL);
      chk({r, st}, {2'h0, 32'h8});
      conn <= 1'b1;
      pause;
      chk(pState, `PWR_ACTIVE);
      conn <= 1'b0;
      boot(1'b1, 7'h2d, 1'b1, 1'b0);
      chk({hvOn, extOn, loadReq}, 3'b010);
      boot(1'b1, 7'h50, 1'b1, 1'b0);
      chk({hvOn, extOn, loadReq}, 3'b001);
      wr(`OFF_CONTROL, 32'h11);
      pause;
      chk({hvOn, loadReq, done}, 3'b101);
      boot(1'b1, 7'h50, 1'b1, 1'b0);
      wr(`OFF_CONTROL, 32'h2);
      pause;
      chk({legacy, portsOn, done}, 3'b101);
      boot(1'b0, 7'h23, 1'b0, 1'b1);
      wr(`OFF_CONTROL, 32'h2);
      pause;
      chk({loadReq, done}, 2'b10);
      for (int i = 0; i < 2; i++) begin
         boot(1'b0, i ? 7'h41 : 7'h0f, 1'b0, 1'b1);
         wr(`OFF_CONTROL, 32'h2);
         pause;
         chk({hvOn, extOn, portsOn, done}, i ? 4'b0111 : 4'b1011);
      end
      completeRun;
   end
endmodule // test_boot_strap_power_sequencer
